// ==== lsmi_map.vh ====
/*
 * Register offsets, field positions, reset values and opcodes of the
 * logic/shift/move/indirect execution unit.
 * Assumes inclusion by bare name from the design file only.
 */
`ifndef LSMI_MAP_VH
`define LSMI_MAP_VH

// ==========================================================
// Register byte offsets
`define LSMI_OFS_CMD 8'h00
`define LSMI_OFS_WREG 8'h04
`define LSMI_OFS_STATUS 8'h08
`define LSMI_OFS_PTR0 8'h0C
`define LSMI_OFS_PTR1 8'h10

// ==========================================================
// Command word fields
`define LSMI_CMD_OP_LSB 0
`define LSMI_CMD_OP_MSB 2
`define LSMI_CMD_DEST 3
`define LSMI_CMD_FADDR_LSB 4
`define LSMI_CMD_FADDR_MSB 10
`define LSMI_CMD_PSEL 11
`define LSMI_CMD_MODE_LSB 12
`define LSMI_CMD_MODE_MSB 13
`define LSMI_CMD_REL 14
`define LSMI_CMD_OFS_LSB 16
`define LSMI_CMD_OFS_MSB 21

// ==========================================================
// Status fields
`define LSMI_ST_CARRY 0
`define LSMI_ST_ZERO 1
`define LSMI_ST_BUSY 8

// ==========================================================
// Opcodes
`define LSMI_OP_OR 3'h0
`define LSMI_OP_LSL 3'h1
`define LSMI_OP_LSR 3'h2
`define LSMI_OP_MOVE_FILE 3'h3
`define LSMI_OP_LDIND 3'h4

// ==========================================================
// Pointer modes
`define LSMI_MODE_PREINC 2'h0
`define LSMI_MODE_PREDEC 2'h1
`define LSMI_MODE_POSTINC 2'h2
`define LSMI_MODE_POSTDEC 2'h3

// ==========================================================
// File addresses of the two indirect windows
`define LSMI_FADDR_WIN0 7'h00
`define LSMI_FADDR_WIN1 7'h01

// ==========================================================
// Reset values
`define LSMI_RST_W 8'h00
`define LSMI_RST_PTR 16'h0000
`define LSMI_RST_FLAGS 1'h0

`endif

// ==== lsmi_exec.v ====
/*
 * Execution unit for OR-with-file, logical shifts, file move and the
 * indirect load through two 16-bit pointers, commanded over APB.
 * Assumes a data memory on the same clock that answers reads and writes
 * with an acknowledge after any number of wait cycles, and an APB master on REF_CLK_I.
 */
//
// Overview of operation
// - OR working register with file register 0..127; only zero flag changes.
// - Destination bit 0 writes working register; 1 writes back to file.
// - Left shift: bit 7 to carry, bits 6:0 up, zero into bit 0.
// - Right shift: zero into bit 7, bits 7:1 down, bit 0 to carry.
// - File move copies to destination and updates zero flag.
// - Indirect load reads pointer-addressed location into working register, sets zero.
// - Mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - Relative form uses pointer plus signed -32..31; pointer unchanged.
// - Pointer ends old plus one, minus one, or unchanged per mode.
// - Indirect windows have no storage; accesses go to pointer address.
// - Pointers are 16 bits and wrap modulo 65536.
// - Pointer stepping never alters status flags.

`timescale 1ns/1ps
`include "lsmi_map.vh"

module lsmi_exec #(
   parameter AW = 8,
   parameter MAW = 16
) (
   input wire REF_CLK_I,              // 100 MHz core clock
   input wire RESET_N_I,              // Asynchronous reset, active low
   input wire PSEL_I,                 // APB select
   input wire PENABLE_I,              // APB enable
   input wire PWRITE_I,               // APB direction, high for write
   input wire [AW-1:0] PADDR_I,       // APB byte address
   input wire [31:0] PWDATA_I,        // APB write data
   output wire [31:0] PRDATA_O,       // APB read data
   output wire PREADY_O,              // APB ready
   output wire PSLVERR_O,             // APB error for unmapped address
   output wire [MAW-1:0] MEM_ADDR_O,  // Data memory address
   output wire MEM_RD_O,              // Data memory read request
   output wire MEM_WR_O,              // Data memory write request
   output wire [7:0] MEM_WDATA_O,     // Data memory write data
   input wire [7:0] MEM_RDATA_I,      // Data memory read data
   input wire MEM_ACK_I,              // Data memory acknowledge
   output wire BUSY_O                 // Command in progress
);

   // ==========================================================
   // Reset release
   reg rst_meta_r;
   reg rst_sync_r;
   wire rst_n;

   // Entry is immediate; exit waits two edges so no flop leaves reset alone
   always @(posedge REF_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rst_meta_r <= 1'h0;
         rst_sync_r <= 1'h0;
      end else begin
         rst_meta_r <= 1'h1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_n = rst_sync_r;

   // ==========================================================
   // Functions

   // Returns {carry, result}; carry is only meaningful for shifts
   function [8:0] lsmi_alu;
      input [2:0] op;
      input [7:0] w;
      input [7:0] f;
      begin
         case (op)
            `LSMI_OP_OR: lsmi_alu = {1'h0, w | f};
            `LSMI_OP_LSL: lsmi_alu = {f[7], f[6:0], 1'h0};
            `LSMI_OP_LSR: lsmi_alu = {f[0], 1'h0, f[7:1]};
            default: lsmi_alu = {1'h0, f};
         endcase
      end
   endfunction

   // Pointer plus a signed 6-bit literal, modulo 16 bits
   function [15:0] lsmi_add_ofs;
      input [15:0] ptr;
      input [5:0] ofs;
      begin
         lsmi_add_ofs = ptr + {{10{ofs[5]}}, ofs};
      end
   endfunction

   // Register write strobe; writes that land while a command runs are dropped
   function lsmi_wr_hit;
      input wr;
      input [AW-1:0] addr;
      input [AW-1:0] ofs;
      input free;
      begin
         lsmi_wr_hit = wr & (addr == ofs) & free;
      end
   endfunction

   // ==========================================================
   // State
   localparam S_IDLE = 2'h0;
   localparam S_READ = 2'h1;
   localparam S_WRITE = 2'h2;

   reg [1:0] state_r;
   reg [7:0] w_r;
   reg carry_r;
   reg zero_r;
   reg [15:0] ptr0_r;
   reg [15:0] ptr1_r;
   reg [2:0] op_r;
   reg dest_r;
   reg [15:0] addr_r;
   reg [7:0] wdata_r;
   reg ptr_upd_r;
   reg ptr_sel_r;
   reg [15:0] ptr_new_r;
   reg [31:0] prdata_r;
   reg pslverr_r;

   wire apb_setup = PSEL_I & ~PENABLE_I;
   wire apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
   wire idle = (state_r == S_IDLE);
   wire cmd_wr = lsmi_wr_hit(apb_wr, PADDR_I, `LSMI_OFS_CMD, idle);
   wire wreg_wr = lsmi_wr_hit(apb_wr, PADDR_I, `LSMI_OFS_WREG, idle);
   wire ptr0_wr = lsmi_wr_hit(apb_wr, PADDR_I, `LSMI_OFS_PTR0, idle);
   wire ptr1_wr = lsmi_wr_hit(apb_wr, PADDR_I, `LSMI_OFS_PTR1, idle);

   // Command decode from write data
   wire [2:0] c_op = PWDATA_I[`LSMI_CMD_OP_MSB:`LSMI_CMD_OP_LSB];
   wire c_dest = PWDATA_I[`LSMI_CMD_DEST];
   wire [6:0] c_faddr = PWDATA_I[`LSMI_CMD_FADDR_MSB:`LSMI_CMD_FADDR_LSB];
   wire c_psel = PWDATA_I[`LSMI_CMD_PSEL];
   wire [1:0] c_mode = PWDATA_I[`LSMI_CMD_MODE_MSB:`LSMI_CMD_MODE_LSB];
   wire c_rel = PWDATA_I[`LSMI_CMD_REL];
   wire [5:0] c_ofs = PWDATA_I[`LSMI_CMD_OFS_MSB:`LSMI_CMD_OFS_LSB];
   // Undefined opcodes are dropped without an error response
   wire c_valid = (c_op <= `LSMI_OP_LDIND);

   wire [15:0] c_ptr = c_psel ? ptr1_r : ptr0_r;
   wire [15:0] c_inc = c_ptr + 16'h0001;
   wire [15:0] c_dec = c_ptr - 16'h0001;
   // File addresses 0 and 1 have no storage; they stand for the pointed-to byte
   wire c_is_win = (c_faddr == `LSMI_FADDR_WIN0) | (c_faddr == `LSMI_FADDR_WIN1);
   wire [15:0] c_win_ptr = c_faddr[0] ? ptr1_r : ptr0_r;

   reg [15:0] c_ea;
   reg [15:0] c_pnew;

   // Effective address and final pointer of an indirect load
   always @* begin
      c_ea = c_ptr;
      c_pnew = c_ptr;
      if (c_rel) begin
         c_ea = lsmi_add_ofs(c_ptr, c_ofs);
      end else begin
         case (c_mode)
            `LSMI_MODE_PREINC: begin
               c_ea = c_inc;
               c_pnew = c_inc;
            end
            `LSMI_MODE_PREDEC: begin
               c_ea = c_dec;
               c_pnew = c_dec;
            end
            `LSMI_MODE_POSTINC: c_pnew = c_inc;
            `LSMI_MODE_POSTDEC: c_pnew = c_dec;
            default: c_pnew = c_ptr;
         endcase
      end
   end

   wire [8:0] alu = lsmi_alu(op_r, w_r, MEM_RDATA_I);
   wire res_zero = (alu[7:0] == 8'h00);
   wire is_shift = (op_r == `LSMI_OP_LSL) | (op_r == `LSMI_OP_LSR);
   wire to_file = dest_r & (op_r != `LSMI_OP_LDIND);

   // ==========================================================
   // Sequencer, working register, flags and pointers
   always @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         w_r <= `LSMI_RST_W;
         carry_r <= `LSMI_RST_FLAGS;
         zero_r <= `LSMI_RST_FLAGS;
         ptr0_r <= `LSMI_RST_PTR;
         ptr1_r <= `LSMI_RST_PTR;
         op_r <= `LSMI_OP_OR;
         dest_r <= 1'h0;
         addr_r <= 16'h0000;
         wdata_r <= 8'h00;
         ptr_upd_r <= 1'h0;
         ptr_sel_r <= 1'h0;
         ptr_new_r <= 16'h0000;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (wreg_wr) begin
                  w_r <= PWDATA_I[7:0];
               end
               if (ptr0_wr) begin
                  ptr0_r <= PWDATA_I[15:0];
               end
               if (ptr1_wr) begin
                  ptr1_r <= PWDATA_I[15:0];
               end
               if (cmd_wr & c_valid) begin
                  op_r <= c_op;
                  dest_r <= c_dest;
                  ptr_sel_r <= c_psel;
                  ptr_new_r <= c_pnew;
                  ptr_upd_r <= (c_op == `LSMI_OP_LDIND);
                  if (c_op == `LSMI_OP_LDIND) begin
                     addr_r <= c_ea;
                  end else if (c_is_win) begin
                     addr_r <= c_win_ptr;
                  end else begin
                     addr_r <= {9'h000, c_faddr};
                  end
                  state_r <= S_READ;
               end
            end
            S_READ: begin
               if (MEM_ACK_I) begin
                  zero_r <= res_zero;
                  if (is_shift) begin
                     carry_r <= alu[8];
                  end
                  // Pointer stepping touches no flag
                  if (ptr_upd_r & ~ptr_sel_r) begin
                     ptr0_r <= ptr_new_r;
                  end
                  if (ptr_upd_r & ptr_sel_r) begin
                     ptr1_r <= ptr_new_r;
                  end
                  if (to_file) begin
                     wdata_r <= alu[7:0];
                     state_r <= S_WRITE;
                  end else begin
                     w_r <= alu[7:0];
                     state_r <= S_IDLE;
                  end
               end
            end
            S_WRITE: begin
               if (MEM_ACK_I) begin
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // APB read path, captured in the setup cycle
   reg [31:0] rd_mux;
   reg rd_err;

   always @* begin
      rd_mux = 32'h00000000;
      rd_err = 1'h0;
      case (PADDR_I)
         `LSMI_OFS_CMD: rd_mux = {29'h00000000, op_r};
         `LSMI_OFS_WREG: rd_mux = {24'h000000, w_r};
         `LSMI_OFS_STATUS: begin
            rd_mux[`LSMI_ST_CARRY] = carry_r;
            rd_mux[`LSMI_ST_ZERO] = zero_r;
            rd_mux[`LSMI_ST_BUSY] = ~idle;
         end
         `LSMI_OFS_PTR0: rd_mux = {16'h0000, ptr0_r};
         `LSMI_OFS_PTR1: rd_mux = {16'h0000, ptr1_r};
         default: rd_err = 1'h1;
      endcase
   end

   always @(posedge REF_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h00000000;
         pslverr_r <= 1'h0;
      end else if (apb_setup) begin
         prdata_r <= PWRITE_I ? 32'h00000000 : rd_mux;
         pslverr_r <= rd_err;
      end
   end

   // Every access completes in its first access cycle
   assign PREADY_O = PSEL_I & PENABLE_I;
   assign PRDATA_O = prdata_r;
   assign PSLVERR_O = pslverr_r & PSEL_I & PENABLE_I;

   // Request levels decode straight from the state flop, so they drop with reset
   assign MEM_ADDR_O = addr_r;
   assign MEM_RD_O = (state_r == S_READ);
   assign MEM_WR_O = (state_r == S_WRITE);
   assign MEM_WDATA_O = wdata_r;
   assign BUSY_O = ~idle;

endmodule

// ==== lsmi_dummy_end.v ====
/*
 * Holds no module: all logic of the execution unit stands in lsmi_exec.v.
 * Assumes nothing of its surroundings.
 */

// ==== lsmi_props.sv ====
/* Port checker for the execution unit.
   Assumes binding onto lsmi_exec. */
`timescale 1ns/1ps
module lsmi_props (
   input wire REF_CLK_I, // Clock
   input wire RESET_N_I, // Reset, active low
   input wire PSEL_I, // Select
   input wire PENABLE_I, // Enable
   input wire PWRITE_I, // Direction
   input wire [7:0] PADDR_I, // Address
   input wire [31:0] PWDATA_I, // Write data
   input wire PREADY_O, // Ready
   input wire PSLVERR_O, // Error
   input wire [15:0] MEM_ADDR_O, // Memory address
   input wire MEM_RD_O, // Memory read
   input wire MEM_WR_O, // Memory write
   input wire [7:0] MEM_WDATA_O, // Memory write data
   input wire MEM_ACK_I, // Memory answer
   input wire BUSY_O // Busy
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   wire acc = PSEL_I && PENABLE_I;
   sequence s_cmd;
      acc && PWRITE_I && PADDR_I == 8'h00 && !BUSY_O && PWDATA_I[2:0] <= 3'h4;
   endsequence
   sequence s_rd_ack;
      MEM_RD_O && MEM_ACK_I;
   endsequence
   sequence s_wr_wait;
      MEM_WR_O && !MEM_ACK_I;
   endsequence
   chk_ready_zero: assert property (PREADY_O == acc)
      else $error("ready not zero wait");
   chk_cmd_start: assert property (s_cmd |=> MEM_RD_O)
      else $error("command gave no read");
   chk_rd_hold: assert property (MEM_RD_O && !MEM_ACK_I |=> MEM_RD_O && $stable(MEM_ADDR_O))
      else $error("read dropped early");
   chk_rd_done: assert property (s_rd_ack |=> !MEM_RD_O)
      else $error("read stayed up");
   chk_wr_after_rd: assert property ($rose(MEM_WR_O) |-> $past(MEM_RD_O && MEM_ACK_I))
      else $error("write without read");
   chk_wr_addr: assert property ($rose(MEM_WR_O) |-> $stable(MEM_ADDR_O))
      else $error("writeback address moved");
   chk_wdata_hold: assert property (s_wr_wait |=> MEM_WR_O && $stable(MEM_WDATA_O))
      else $error("writeback data moved");
   chk_one_dir: assert property (!(MEM_RD_O && MEM_WR_O))
      else $error("read and write together");
   chk_busy_ends: assert property (s_rd_ack ##1 !MEM_WR_O |-> !BUSY_O)
      else $error("busy after last access");
   chk_idle_quiet: assert property (!BUSY_O |-> !MEM_RD_O && !MEM_WR_O)
      else $error("memory access while idle");
   chk_err_gate: assert property (PSLVERR_O |-> acc)
      else $error("error outside access");
endmodule

// ==== lsmi_mem_model.sv ====
/* Data memory model with adjustable answer delay.
   Assumes requests held until the answer. */
`timescale 1ns/1ps
module lsmi_mem_model (
   input wire clk_i, // Core clock
   input wire [15:0] addr_i, // Address
   input wire rd_i, // Read request
   input wire wr_i, // Write request
   input wire [7:0] wdata_i, // Write data
   input wire [3:0] lat_i, // Wait cycles before answering
   output wire [7:0] rdata_o, // Read data
   output wire ack_o // Answer
);
   logic [7:0] mem [0:65535];
   logic [3:0] wait_r;
   assign ack_o = (rd_i || wr_i) && wait_r == lat_i;
   // Inverted data outside an answer so a stale sample cannot match
   assign rdata_o = (ack_o && rd_i) ? mem[addr_i] : ~mem[addr_i];
   always @(posedge clk_i) begin
      wait_r <= (ack_o || !(rd_i || wr_i)) ? 4'h0 : wait_r + 4'h1;
      if (ack_o && wr_i) mem[addr_i] <= wdata_i;
   end
endmodule

// ==== lsmi_exec_tb_top.sv ====
/* Self-checking bench for lsmi_exec.
   Assumes the checker and memory model compile first. */
`timescale 1ns/1ps
module lsmi_exec_tb_top;
   typedef struct {logic [2:0] op; logic d; logic [6:0] fa; logic [7:0] fv, w, res; logic c, z;} lsmi_row_t;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, err;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [15:0] a, p;
   logic [3:0] lat = 0;
   wire [31:0] prdata;
   wire pready, pslverr, mrd, mwr, mack, busy;
   wire [15:0] maddr;
   wire [7:0] mwdata, mrdata;
   int n_fail = 0, check_count = 0;
   lsmi_row_t rows[9] = '{'{0, 0, 7'h20, 8'h00, 8'h00, 8'h00, 0, 1}, '{1, 0, 7'h21, 8'h81, 0, 8'h02, 1, 0},
      '{0, 0, 7'h7F, 8'h50, 8'h0A, 8'h5A, 1, 0}, '{2, 0, 7'h22, 8'h01, 0, 8'h00, 1, 1},
      '{2, 1, 7'h23, 8'h80, 8'h33, 8'h40, 0, 0}, '{1, 1, 7'h24, 8'h80, 8'h44, 8'h00, 1, 1},
      '{3, 1, 7'h25, 8'h00, 8'h12, 8'h00, 1, 1}, '{3, 0, 7'h26, 8'hC3, 0, 8'hC3, 1, 0},
      '{0, 1, 7'h27, 8'h0F, 8'hF0, 8'hFF, 1, 0}};
   always #5 clk = ~clk;
   lsmi_exec uut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .MEM_ADDR_O(maddr), .MEM_RD_O(mrd), .MEM_WR_O(mwr),
      .MEM_WDATA_O(mwdata), .MEM_RDATA_I(mrdata), .MEM_ACK_I(mack), .BUSY_O(busy));
   lsmi_mem_model mdl (.clk_i(clk), .addr_i(maddr), .rd_i(mrd), .wr_i(mwr), .wdata_i(mwdata),
      .lat_i(lat), .rdata_o(mrdata), .ack_o(mack));
   // ==========================================
   // Shared tasks
   function logic [31:0] cmdw(input logic [2:0] op, input logic d, input logic [6:0] fa,
      input logic ps, input logic [1:0] m, input logic rel, input logic [5:0] ofs);
      return {10'h0, ofs, 1'b0, rel, m, ps, fa, d, op};
   endfunction
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         conclude;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   task wait_idle;
      int n;
      n = 0;
      do begin
         apb(0, 8'h08, 0);
         n++;
      end while (rd[8] !== 1'b0 && n < 30);
      if (n >= 30) begin
         n_fail++;
         conclude;
      end
   endtask
   task run(input logic [31:0] c);
      apb(1, 8'h00, c);
      wait_idle;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      for (int r = 1; r < 5; r++) begin
         apb(0, r * 4, 0);
         chk("reset value", rd, 0);
      end
      apb(0, 8'h14, 0);
      chk("unmapped error", err, 1);
      apb(1, 8'h14, 32'hFF);
      chk("unmapped write error", err, 1);
      foreach (rows[i]) begin
         mdl.mem[{9'h0, rows[i].fa}] = rows[i].fv;
         apb(1, 8'h04, rows[i].w);
         run(cmdw(rows[i].op, rows[i].d, rows[i].fa, 0, 0, 0, 0));
         apb(0, 8'h04, 0);
         chk("wreg", rd, rows[i].d ? rows[i].w : rows[i].res);
         chk("file", mdl.mem[{9'h0, rows[i].fa}], rows[i].d ? rows[i].res : rows[i].fv);
         apb(0, 8'h08, 0);
         chk("flags", rd, {rows[i].z, rows[i].c});
      end
      // Slow answers from here on keep the unit busy for a while
      lat <= 4'h3;
      for (int m = 0; m < 4; m++) begin
         p = m[0] ? 16'h0000 : 16'hFFFF;
         a = m < 2 ? (m[0] ? p - 1 : p + 1) : p;
         mdl.mem[a] = m * 17;
         apb(1, m[0] ? 8'h10 : 8'h0C, p);
         run(cmdw(4, 0, 0, m[0], m[1:0], 0, 0));
         apb(0, 8'h04, 0);
         chk("load data", rd, m * 17);
         apb(0, 8'h08, 0);
         chk("load flags", rd, {m == 0, 1'b1});
         apb(0, m[0] ? 8'h10 : 8'h0C, 0);
         chk("pointer", rd, m[0] ? 16'hFFFF : 16'h0000);
      end
      apb(1, 8'h0C, 32'h10);
      for (int k = 0; k < 2; k++) begin
         mdl.mem[k ? 16'h002F : 16'hFFF0] = 8'h60 + k;
         run(cmdw(4, 0, 0, 0, 2'h3, 1, k ? 6'h1F : 6'h20));
         apb(0, 8'h04, 0);
         chk("offset data", rd, 8'h60 + k);
         apb(0, 8'h0C, 0);
         chk("offset pointer", rd, 32'h10);
      end
      mdl.mem[16'h0010] = 8'h0C;
      apb(1, 8'h04, 32'hC0);
      run(cmdw(0, 1, 7'h00, 0, 0, 0, 0));
      chk("window writeback", mdl.mem[16'h0010], 8'hCC);
      apb(0, 8'h04, 0);
      chk("window wreg", rd, 8'hC0);
      apb(0, 8'h08, 0);
      chk("window flags", rd, 32'h1);
      apb(1, 8'h10, 32'h1234);
      mdl.mem[16'h1234] = 8'h77;
      apb(1, 8'h00, cmdw(3, 0, 1, 0, 0, 0, 0));
      apb(1, 8'h04, 32'h55);
      wait_idle;
      apb(0, 8'h04, 0);
      chk("window data", rd, 8'h77);
      apb(0, 8'h10, 0);
      chk("window pointer", rd, 32'h1234);
      apb(1, 8'h00, cmdw(3'h5, 0, 7'h20, 0, 0, 0, 0));
      apb(0, 8'h08, 0);
      chk("bad op busy", rd[8], 0);
      apb(0, 8'h00, 0);
      chk("last op", rd, 3);
      // Reset while a slow load is in flight: nothing may commit
      apb(1, 8'h0C, 32'h55);
      apb(1, 8'h00, cmdw(4, 0, 0, 0, 2'h2, 0, 0));
      rst_n <= 0;
      repeat (3) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      for (int r = 1; r < 5; r++) begin
         apb(0, r * 4, 0);
         chk("mid-run reset", rd, 0);
      end
      conclude;
   end
endmodule
bind lsmi_exec lsmi_props chk_u (.REF_CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
   .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O, .MEM_ADDR_O, .MEM_RD_O, .MEM_WR_O,
   .MEM_WDATA_O, .MEM_ACK_I, .BUSY_O);
